/* logic/uart_regs.sv */
// Host register map and FIFO control of the serial communications element
`include "uart_regs_defs.svh"
module uart_regs (
  input  wire logic                    mclk,
  input  wire logic                    sys_rst,
  input  wire uart_regs_pkg::bus_req_t bus_req,
  output logic [7:0]                   rdata,
  input  wire logic [7:0]              rx_char,
  input  wire logic                    rx_char_valid,
  input  wire uart_regs_pkg::rx_err_t  rx_char_err,
  input  wire logic                    tx_char_ready,
  output logic [7:0]                   tx_char,
  output logic                         tx_char_valid,
  output logic                         tx_stage_ready,
  input  wire logic                    tx_shift_empty,
  input  wire logic [3:0]              modem_lines,
  input  wire logic [3:0]              modem_deltas,
  input  wire logic                    irq_pending,
  input  wire logic [2:0]              irq_code,
  output logic [7:0]                   line_control,
  output logic [7:0]                   modem_control,
  output logic [7:0]                   irq_enable,
  output logic [15:0]                  baud_divisor,
  output logic                         fifo_mode,
  output logic                         rx_data_present,
  output logic                         rx_trigger_hit,
  output logic                         rx_dma_request_n,
  output logic                         tx_dma_request_n
);
  uart_regs_pkg::fifo_ctrl_t fctl;
  logic [7:0]  scratch;
  logic [7:0]  rx_buffer;
  logic [7:0]  rx_buffer_hold;
  logic        rx_hold_full;
  logic        tx_hold_full;
  logic [7:0]  tx_hold;
  logic [4:0]  rx_cnt;
  logic [4:0]  tx_cnt;
  logic [4:0]  trig_n;
  logic        rx_flush;
  logic        tx_flush;
  logic        rx_err_any;
  logic        dla;
  logic        fcr_wr;
  logic        rx_pop;
  logic        tx_push;
  logic        stage_v;
  logic [7:0]  stage_d;
  logic        stage_rdy;
  logic [7:0]  rx_head;
  logic        rx_head_v;
  logic        tx_fifo_rdy;
  logic        rx_fifo_rdy;
  logic [7:0]  next_rdata;
  logic [7:0]  err_flags;

  assign dla     = line_control[`LCR_DLA_BIT];
  assign fcr_wr  = bus_req.wr && bus_req.addr == `OFS_IRQ_ID;
  assign rx_pop  = bus_req.rd && bus_req.addr == `OFS_DATA && !dla;
  assign tx_push = bus_req.wr && bus_req.addr == `OFS_DATA && !dla;

  // Flush on clear bits written with the enable bit set, or on a change of the enable bit
  always_comb
  begin
    rx_flush = 1'b0;
    tx_flush = 1'b0;
    if (fcr_wr)
    begin
      if (bus_req.wdata[`FCR_ENABLE_BIT] != fctl.enable)
      begin
        rx_flush = 1'b1;
        tx_flush = 1'b1;
      end
      if (bus_req.wdata[`FCR_ENABLE_BIT])
      begin
        rx_flush = rx_flush || bus_req.wdata[`FCR_RXCLR_BIT];
        tx_flush = tx_flush || bus_req.wdata[`FCR_TXCLR_BIT];
      end
    end
  end

  // Clear bits are not stored, so they read back as self-cleared; bits 5:4 dropped
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      fctl <= '0;
    else if (fcr_wr)
    begin
      fctl.enable <= bus_req.wdata[`FCR_ENABLE_BIT];
      if (bus_req.wdata[`FCR_ENABLE_BIT])
      begin
        fctl.dma_mode <= bus_req.wdata[`FCR_DMA_BIT];
        fctl.trigger  <= bus_req.wdata[7:6];
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      line_control  <= '0;
      modem_control <= '0;
      irq_enable    <= '0;
    end
    else if (bus_req.wr)
    begin
      if (bus_req.addr == `OFS_LINE_CTRL)
        line_control <= bus_req.wdata;
      if (bus_req.addr == `OFS_MODEM_CTRL)
        modem_control <= bus_req.wdata & `MCR_MASK;
      if (bus_req.addr == `OFS_IRQ_ENABLE && !dla)
        irq_enable <= bus_req.wdata & `IER_MASK;
    end
  end

  // Divisor and scratch are untouched by reset
  always_ff @(posedge mclk)
  begin
    if (bus_req.wr && dla && bus_req.addr == `OFS_DATA)
      baud_divisor[7:0] <= bus_req.wdata;
    if (bus_req.wr && dla && bus_req.addr == `OFS_IRQ_ENABLE)
      baud_divisor[15:8] <= bus_req.wdata;
    if (bus_req.wr && bus_req.addr == `OFS_SCRATCH)
      scratch <= bus_req.wdata;
  end

  // Transmit path: host write -> staging FIFO -> 16-byte FIFO -> shifter
  byte_fifo #(.WIDTH(8), .DEPTH(`STAGE_DEPTH), .CW(3)) u_stage (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .flush     (tx_flush),
    .in_data   (bus_req.wdata),
    .in_valid  (tx_push),
    .in_ready  (stage_rdy),
    .out_data  (stage_d),
    .out_valid (stage_v),
    .out_ready (tx_fifo_rdy),
    .count     ()
  );

  // In character mode the transmit FIFO holds one character only
  byte_fifo #(.WIDTH(8), .DEPTH(`FIFO_DEPTH), .CW(`FIFO_CNT_W)) u_tx (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .flush     (tx_flush),
    .in_data   (stage_d),
    .in_valid  (stage_v && (fctl.enable || tx_cnt == '0)),
    .in_ready  (tx_fifo_rdy),
    .out_data  (tx_hold),
    .out_valid (tx_hold_full),
    .out_ready (tx_char_ready),
    .count     (tx_cnt)
  );

  // Receive FIFO: in character mode a new byte is dropped while one byte is held (depth-1 use)
  byte_fifo #(.WIDTH(8), .DEPTH(`FIFO_DEPTH), .CW(`FIFO_CNT_W)) u_rx (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .flush     (rx_flush),
    .in_data   (rx_char),
    .in_valid  (rx_char_valid && (fctl.enable || rx_cnt == '0)),
    .in_ready  (rx_fifo_rdy),
    .out_data  (rx_head),
    .out_valid (rx_head_v),
    .out_ready (rx_pop),
    .count     (rx_cnt)
  );

  assign rx_buffer      = rx_head;
  assign rx_buffer_hold = rx_buffer;
  assign rx_hold_full   = rx_head_v;

  always_comb
  begin
    unique case (fctl.trigger)
      2'b00: trig_n = 5'h01;
      2'b01: trig_n = 5'h04;
      2'b10: trig_n = 5'h08;
      2'b11: trig_n = 5'h0E;
    endcase
  end

  // Sticky error summary for line status
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      err_flags <= '0;
    else if (bus_req.rd && bus_req.addr == `OFS_LINE_STAT)
      err_flags <= '0;
    else if (rx_char_valid)
      err_flags <= err_flags | {4'h0, rx_char_err};
    if (!sys_rst && rx_char_valid && !rx_fifo_rdy)
      err_flags[0] <= 1'b1;
  end
  assign rx_err_any = |err_flags[3:1];

  always_comb
  begin
    next_rdata = 8'h00;
    unique case (bus_req.addr)
      `OFS_DATA:       next_rdata = dla ? baud_divisor[7:0] : rx_buffer_hold;
      `OFS_IRQ_ENABLE: next_rdata = dla ? baud_divisor[15:8] : irq_enable;
      `OFS_IRQ_ID:     next_rdata = {{2{fctl.enable}}, 2'b00,
                                     irq_code[2] & fctl.enable, irq_code[1:0], ~irq_pending};
      `OFS_LINE_CTRL:  next_rdata = line_control;
      `OFS_MODEM_CTRL: next_rdata = modem_control;
      `OFS_LINE_STAT:  next_rdata = {rx_err_any & fctl.enable,
                                     !tx_hold_full && tx_cnt == '0 && tx_shift_empty,
                                     tx_cnt == '0 && !stage_v,
                                     err_flags[1], err_flags[2], err_flags[3], err_flags[0],
                                     rx_hold_full};
      `OFS_MODEM_STAT: next_rdata = {modem_lines, modem_deltas};
      `OFS_SCRATCH:    next_rdata = scratch;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      rdata <= '0;
    else if (bus_req.rd)
      rdata <= next_rdata;
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      fifo_mode        <= 1'b0;
      rx_data_present  <= 1'b0;
      rx_trigger_hit   <= 1'b0;
      tx_char          <= '0;
      tx_char_valid    <= 1'b0;
      tx_stage_ready   <= 1'b1;
      rx_dma_request_n <= 1'b1;
      tx_dma_request_n <= 1'b1;
    end
    else
    begin
      fifo_mode       <= fctl.enable;
      rx_data_present <= rx_cnt != '0;
      rx_trigger_hit  <= fctl.enable ? (rx_cnt >= trig_n) : (rx_cnt != '0);
      tx_char         <= tx_hold;
      tx_char_valid   <= tx_hold_full && !tx_char_ready;
      tx_stage_ready  <= stage_rdy;
      if (fctl.enable && fctl.dma_mode)
      begin
        rx_dma_request_n <= !(rx_cnt >= trig_n);
        tx_dma_request_n <= tx_cnt == 5'(`FIFO_DEPTH);
      end
      else
      begin
        rx_dma_request_n <= rx_cnt == '0;
        tx_dma_request_n <= tx_cnt != '0;
      end
    end
  end
endmodule // uart_regs

/* logic/uart_regs_defs.svh */
// Register offsets, field positions, reset values and depths of the serial register block
`ifndef UART_REGS_DEFS_SVH
`define UART_REGS_DEFS_SVH
`define OFS_DATA        3'h0
`define OFS_IRQ_ENABLE  3'h1
`define OFS_IRQ_ID      3'h2
`define OFS_LINE_CTRL   3'h3
`define OFS_MODEM_CTRL  3'h4
`define OFS_LINE_STAT   3'h5
`define OFS_MODEM_STAT  3'h6
`define OFS_SCRATCH     3'h7
`define FCR_ENABLE_BIT  0
`define FCR_RXCLR_BIT   1
`define FCR_TXCLR_BIT   2
`define FCR_DMA_BIT     3
`define LCR_DLA_BIT     7
`define IER_MASK        8'h0F
`define MCR_MASK        8'h3F
`define LSR_RESET       8'h60
`define FIFO_DEPTH      16
`define FIFO_CNT_W      5
`define STAGE_DEPTH     4
`endif

/* logic/uart_regs_pkg.sv */
// Types shared by the serial register block
package uart_regs_pkg;
  typedef struct packed {
    logic [2:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } bus_req_t;

  typedef struct packed {
    logic [1:0] trigger;
    logic       dma_mode;
    logic       enable;
  } fifo_ctrl_t;

  typedef struct packed {
    logic parity_fault;
    logic framing_fault;
    logic break_seen;
    logic overrun;
  } rx_err_t;

  typedef enum logic [1:0] {
    RX_IDLE,
    RX_WAIT
  } rx_load_state_t;
endpackage

/* logic/byte_fifo.sv */
// Synchronous FIFO with valid/ready on both sides and registered read data
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int CW    = 5
) (
  input  wire logic             mclk,
  input  wire logic             sys_rst,
  input  wire logic             flush,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [CW-1:0]         count
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic             push;
  logic             pop;
  logic [AW-1:0]    rd_next;

  assign push = in_valid && in_ready;
  assign rd_next = pop ? ((rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1) : rd_ptr;
  assign pop  = out_valid && out_ready;
  assign in_ready = (count != CW'(DEPTH));

  always_ff @(posedge mclk)
  begin
    if (push)
      mem[wr_ptr] <= in_data;
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst || flush)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      if (push && !pop)
        count <= count + 1'b1;
      else if (pop && !push)
        count <= count - 1'b1;
    end
  end

  // Head word registered; a word written into the head slot bypasses memory
  always_ff @(posedge mclk)
  begin
    if (sys_rst || flush)
    begin
      out_data  <= '0;
      out_valid <= 1'b0;
    end
    else
    begin
      out_data  <= (push && wr_ptr == rd_next) ? in_data : mem[rd_next];
      out_valid <= pop ? (count > CW'(1)) || push : (count != '0) || push;
    end
  end
endmodule // byte_fifo

/* sim/uart_regs_asserts.sv */
// Checker of register map and FIFO control behaviour
module uart_regs_asserts (
  input wire logic                    mclk,
  input wire logic                    sys_rst,
  input wire uart_regs_pkg::bus_req_t bus_req,
  input wire logic [7:0]              rdata,
  input wire logic [7:0]              line_control,
  input wire logic [7:0]              modem_control,
  input wire logic [15:0]             baud_divisor,
  input wire logic                    irq_pending,
  input wire logic                    fifo_mode,
  input wire logic                    rx_char_valid,
  input wire logic                    rx_data_present,
  input wire logic                    rx_trigger_hit
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  sequence s_id_rd;
    bus_req.rd && bus_req.addr == 3'h2;
  endsequence
  sequence s_fc_wr;
    bus_req.wr && bus_req.addr == 3'h2;
  endsequence
  a_id_pending:
    assert property (s_id_rd |=> rdata[0] == !$past(irq_pending)) else $error("pending bit wrong");
  a_id_fifo_bits:
    assert property (s_id_rd |=> rdata[7:6] == {2{$past(fifo_mode)}} && rdata[5:4] == 2'h0)
      else $error("mode bits wrong");
  a_id_char_mode:
    assert property (s_id_rd ##0 !fifo_mode |=> rdata[3] == 1'h0) else $error("timeout bit set");
  a_enable_kept_off:
    assert property (s_fc_wr ##0 !bus_req.wdata[0] && !fifo_mode && !$past(bus_req.wr) |=> !fifo_mode [*2])
      else $error("mode set without enable");
  a_enable_on:
    assert property (s_fc_wr ##0 bus_req.wdata[0] |-> ##[1:2] fifo_mode) else $error("mode not set");
  a_divisor_low:
    assert property (bus_req.wr && bus_req.addr == 3'h0 && line_control[7]
      |=> baud_divisor[7:0] == $past(bus_req.wdata)) else $error("divisor not written");
  a_modem_mask:
    assert property (bus_req.wr && bus_req.addr == 3'h4 |=> modem_control == ($past(bus_req.wdata) & 8'h3F))
      else $error("modem control wrong");
  a_rx_flush:
    assert property (s_fc_wr ##0 bus_req.wdata[1:0] == 2'h3 && !rx_char_valid |-> ##[1:3] !rx_data_present)
      else $error("receive not flushed");
  a_trigger_data:
    assert property (rx_trigger_hit |-> rx_data_present) else $error("trigger without data");
endmodule // uart_regs_asserts

bind uart_regs uart_regs_asserts u_chk (.mclk, .sys_rst, .bus_req, .rdata, .line_control, .modem_control,
  .baud_divisor, .irq_pending, .fifo_mode, .rx_char_valid, .rx_data_present, .rx_trigger_hit);

/* sim/tx_shift_model.sv */
// Shifter-side model taking characters off the transmit path
module tx_shift_model (
  input  wire logic mclk,
  input  wire logic sys_rst,
  input  wire logic stall,
  input  wire logic tx_char_valid,
  output logic      tx_char_ready,
  output logic      tx_shift_empty
);
  timeunit 1ns;
  timeprecision 1ns;
  logic ready_d;
  // Pop pulse, then two rest cycles while the offered char updates
  always_ff @(posedge mclk)
  begin
    tx_char_ready <= !sys_rst && tx_char_valid && !stall && !tx_char_ready && !ready_d;
    ready_d <= tx_char_ready;
    tx_shift_empty <= sys_rst || !tx_char_valid;
  end
endmodule // tx_shift_model

/* sim/uart_regs_bench.sv */
// Self-checking bench of the serial register block
module uart_regs_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, sys_rst, rx_char_valid, irq_pending, stall, tx_char_ready, tx_shift_empty, rd_seen, full;
  logic tx_char_valid, tx_stage_ready, fifo_mode, rx_data_present, rx_trigger_hit, rx_dma_n, tx_dma_n;
  uart_regs_pkg::bus_req_t bus_req;
  logic [7:0]  rdata, rx_char, tx_char, line_control, modem_control, d;
  logic [15:0] baud_divisor;
  logic [15:0] rd_q[$];
  logic [7:0]  tx_q[$], rx_q[$];
  int          n_errors, checks_done, cyc, seed, lvl;

  uart_regs dut (.mclk(mclk), .sys_rst(sys_rst), .bus_req(bus_req), .rdata(rdata), .rx_char(rx_char),
    .rx_char_valid(rx_char_valid), .rx_char_err('0), .tx_char_ready(tx_char_ready), .tx_char(tx_char),
    .tx_char_valid(tx_char_valid), .tx_stage_ready(tx_stage_ready), .tx_shift_empty(tx_shift_empty),
    .modem_lines(4'h0), .modem_deltas(4'h0), .irq_pending(irq_pending), .irq_code(3'h7),
    .line_control(line_control), .modem_control(modem_control), .irq_enable(), .baud_divisor(baud_divisor),
    .fifo_mode(fifo_mode), .rx_data_present(rx_data_present), .rx_trigger_hit(rx_trigger_hit),
    .rx_dma_request_n(rx_dma_n), .tx_dma_request_n(tx_dma_n));
  tx_shift_model model (.mclk(mclk), .sys_rst(sys_rst), .stall(stall), .tx_char_valid(tx_char_valid),
    .tx_char_ready(tx_char_ready), .tx_shift_empty(tx_shift_empty));

  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task end_of_test;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task cmp(input logic [15:0] g, e);
    checks_done++;
    if (g !== e)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task flag(input logic f, e);
    cmp({15'h0, f}, {15'h0, e});
  endtask

  task wr(input logic [2:0] a, input logic [7:0] v);
    @(negedge mclk);
    bus_req = {a, 1'b1, 1'b0, v};
    @(negedge mclk);
    bus_req.wr = 1'b0;
  endtask

  // Expected value and mask noted before the read is issued
  task rd(input logic [2:0] a, input logic [7:0] e, m);
    rd_q.push_back({m, e & m});
    @(negedge mclk);
    bus_req = {a, 1'b0, 1'b1, 8'h00};
    @(negedge mclk);
    bus_req.rd = 1'b0;
  endtask

  task push_rx;
    @(negedge mclk);
    d = 8'($random(seed));
    rx_q.push_back(d);
    rx_char = d;
    rx_char_valid = 1'b1;
    @(negedge mclk);
    rx_char_valid = 1'b0;
    rx_char = ~d;
  endtask

  always @(posedge mclk)
    rd_seen <= bus_req.rd;

  always @(negedge mclk)
    if (rd_seen && rd_q.size() > 0)
    begin
      cmp({8'h00, rdata & rd_q[0][15:8]}, {8'h00, rd_q[0][7:0]});
      void'(rd_q.pop_front());
    end

  always @(posedge mclk)
    if (tx_char_valid && tx_char_ready && tx_q.size() > 0)
    begin
      cmp({8'h00, tx_char}, {8'h00, tx_q[0]});
      void'(tx_q.pop_front());
    end

  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      n_errors++;
      end_of_test;
    end
  end

  initial
  begin
    seed = 42043;
    sys_rst = 1'b1;
    bus_req = '0;
    rx_char = 8'h00;
    rx_char_valid = 1'b0;
    irq_pending = 1'b0;
    stall = 1'b0;
    full = 1'b0;
    repeat (5) @(negedge mclk);
    sys_rst = 1'b0;
    rd(3'h2, 8'h01, 8'hF9);
    wr(3'h2, 8'hC0);
    repeat (3) @(negedge mclk);
    flag(fifo_mode, 1'b0);
    irq_pending = 1'b1;
    wr(3'h2, 8'hF9);
    repeat (3) @(negedge mclk);
    flag(fifo_mode, 1'b1);
    rd(3'h2, 8'hC0, 8'hF1);
    flag(rx_dma_n, 1'b1);
    flag(tx_dma_n, 1'b0);
    for (int i = 0; i < 4; i++)
    begin
      lvl = (i == 3) ? 14 : (i == 2) ? 8 : (i == 1) ? 4 : 1;
      wr(3'h2, {2'(i), 6'h03});
      rx_q.delete();
      repeat (lvl - 1) push_rx;
      repeat (3) @(negedge mclk);
      flag(rx_trigger_hit, 1'b0);
      push_rx;
      repeat (3) @(negedge mclk);
      flag(rx_trigger_hit, 1'b1);
    end
    rd(3'h0, rx_q[0], 8'hFF);
    repeat (3) @(negedge mclk);
    flag(rx_trigger_hit, 1'b0);
    wr(3'h2, 8'hC3);
    repeat (3) @(negedge mclk);
    flag(rx_data_present, 1'b0);
    push_rx;
    wr(3'h2, 8'h00);
    repeat (3) @(negedge mclk);
    flag(rx_data_present, 1'b0);
    rd(3'h2, 8'h00, 8'hF9);
    wr(3'h3, 8'h80);
    wr(3'h0, 8'h5A);
    wr(3'h1, 8'hA5);
    rd(3'h0, 8'h5A, 8'hFF);
    cmp(baud_divisor, 16'hA55A);
    wr(3'h3, 8'h1B);
    rd(3'h3, 8'h1B, 8'hFF);
    wr(3'h4, 8'hFF);
    rd(3'h4, 8'h3F, 8'hFF);
    d = 8'($random(seed));
    wr(3'h7, d);
    rd(3'h7, d, 8'hFF);
    wr(3'h1, 8'hFF);
    rd(3'h1, 8'h0F, 8'hFF);
    wr(3'h2, 8'h01);
    stall = 1'b1;
    for (int k = 0; k < 24; k++)
    begin
      // Ready is registered: let it catch up with the last write
      @(negedge mclk);
      if (!tx_stage_ready)
      begin
        full = 1'b1;
        stall = 1'b0;
      end
      repeat (200) if (!tx_stage_ready) @(negedge mclk);
      d = 8'($random(seed));
      tx_q.push_back(d);
      wr(3'h0, d);
    end
    flag(full, 1'b1);
    repeat (2000) if (tx_q.size() > 0)
    begin
      stall = 1'($random(seed));
      @(negedge mclk);
    end
    flag(tx_q.size() == 0, 1'b1);
    repeat (4) @(negedge mclk);
    rd(3'h5, 8'h60, 8'h61);
    repeat (2) @(negedge mclk);
    end_of_test;
  end
endmodule // uart_regs_bench
